// File: opstat_chk_sva.sv
// checker for the operation status command port
`timescale 1ns/1ps
`default_nettype none
module opstat_chk
  import opstat_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        current_regulation_flag,
  input wire logic        voltage_regulation_flag,
  input wire logic        current_fault_flag,
  input wire logic        voltage_fault_flag,
  input wire logic        current_mode_live_flag,
  input wire logic        voltage_mode_live_flag,
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic [7:0]  status_byte
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // query decode; only these may raise the answer strobe
  wire logic is_q = cmd_valid && cmd_code inside {4'h0, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8};
  chk_query_answer: assert property (is_q |=> rsp_valid)
    else $error("query without answer");
  chk_no_stray: assert property (!is_q |=> !rsp_valid)
    else $error("answer without query");
  chk_cond_layout: assert property (is_q && cmd_code == 4'h0 |=> !(rsp_data & 16'hfaff))
    else $error("condition bit outside 10 and 8");
  chk_oper_range: assert property (is_q && cmd_code[3:1] == 3'h1 |=> !(rsp_data & 16'hfade))
    else $error("operation value out of range");
  chk_mask_off: assert property (cmd_valid && cmd_code == 4'h1 && !cmd_data |-> ##2 !status_byte[7])
    else $error("summary set with empty mask");
  chk_reset_idle: assert property ($rose(resetn) |-> !status_byte && !rsp_valid)
    else $error("outputs not idle after reset");
  chk_mask_back: assert property (cmd_valid && cmd_code == 4'h1 ##2 cmd_valid && cmd_code == 4'h2
    |=> rsp_data == ($past(cmd_data, 3) & OPSTAT_OPER_DEF)) else $error("mask readback wrong");
  chk_ques_latch: assert property (is_q && cmd_code == 4'h6 |=> !(rsp_data & 16'hcfff))
    else $error("questionable event outside 13 and 12");
endmodule // opstat_chk
bind opstat_top opstat_chk u_chk (.core_clk, .resetn, .current_regulation_flag,
  .voltage_regulation_flag, .current_fault_flag, .voltage_fault_flag, .current_mode_live_flag,
  .voltage_mode_live_flag, .cmd_valid, .cmd_code, .cmd_data, .rsp_valid, .rsp_data, .status_byte);
`default_nettype wire

// File: opstat_host.sv
// host controller model issuing status commands
`timescale 1ns/1ps
`default_nettype none
module opstat_host (
  input  wire logic        core_clk,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  output var  logic        cmd_valid,
  output var  logic [3:0]  cmd_code,
  output var  logic [15:0] cmd_data
);
  initial cmd_valid = 1'b0;
  // mask sent as one word; data inverted after release so it never looks valid
  task automatic send(input logic [3:0] c, input logic [15:0] d);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_data  <= d;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    cmd_data  <= ~d;
  endtask
  // answer due at the taking edge and checked 1 ns later; a late one ends the run
  task automatic query(input logic [3:0] c, output logic [15:0] q);
    send(c, 16'h0000);
    #1;
    if (rsp_valid !== 1'b1)
      testbench.stop_test(1'b1);
    q = rsp_data;
  endtask
endmodule // opstat_host
`default_nettype wire

// File: opstat_pkg.sv
// shared constants and command codes for the operation status group
package opstat_pkg;
  localparam int unsigned OPSTAT_WIDTH      = 16;
  // operation layout
  localparam int unsigned OPSTAT_CUR_BIT    = 10;
  localparam int unsigned OPSTAT_VOLT_BIT   = 8;
  localparam logic [15:0] OPSTAT_OPER_DEF   = 16'h0521; // bits 0, 5, 8, 10
  // questionable layout
  localparam int unsigned OPSTAT_QCE_BIT    = 13;
  localparam int unsigned OPSTAT_QVE_BIT    = 12;
  localparam int unsigned OPSTAT_QCM_BIT    = 1;
  localparam int unsigned OPSTAT_QVM_BIT    = 0;
  localparam logic [15:0] OPSTAT_QUES_DEF   = 16'h3003;
  localparam logic [15:0] OPSTAT_QUES_LATCH = 16'h3000;
  // status byte summary positions
  localparam int unsigned OPSTAT_OPER_SUM   = 7;
  localparam int unsigned OPSTAT_QUES_SUM   = 3;
  // reset values
  localparam logic [15:0] OPSTAT_ZERO       = 16'h0000;

  typedef enum logic [3:0] {
    OPSTAT_CMD_OPER_COND_Q = 4'h0,
    OPSTAT_CMD_OPER_ENAB_W = 4'h1,
    OPSTAT_CMD_OPER_ENAB_Q = 4'h2,
    OPSTAT_CMD_OPER_EVEN_Q = 4'h3,
    OPSTAT_CMD_PRESET      = 4'h4,
    OPSTAT_CMD_QUES_COND_Q = 4'h5,
    OPSTAT_CMD_QUES_EVEN_Q = 4'h6,
    OPSTAT_CMD_QUES_ENAB_W = 4'h7,
    OPSTAT_CMD_QUES_ENAB_Q = 4'h8
  } opstat_cmd_t;
endpackage

// File: opstat_top.sv
// operation and questionable status registers behind a command port
// Functional notes
// - current regulation at bit 10, voltage regulation at bit 8, others unused
// - operation condition register follows live regulation flags, no latching
// - enable mask is writable and reads back the stored mask
// - status byte bit 7 is OR of enabled operation event bits
// - event register is read-only and holds each event until read
// - event read returns latched contents then clears them
// - entering voltage regulation sets event value 256, second read gives zero
// - preset zeroes operation and questionable condition registers
// - questionable bits 13, 12, 1, 0; only 13 and 12 latch
`timescale 1ns/1ps
`default_nettype none
module opstat_top
  import opstat_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        current_regulation_flag,
  input  wire logic        voltage_regulation_flag,
  input  wire logic        current_fault_flag,
  input  wire logic        voltage_fault_flag,
  input  wire logic        current_mode_live_flag,
  input  wire logic        voltage_mode_live_flag,
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_code,
  input  wire logic [15:0] cmd_data,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic [7:0]       status_byte
);

  // flag pin synchronisers
  logic [5:0]  sync_a;
  logic [5:0]  sync_b;

  // operation group registers
  logic [15:0] operation_live_condition;
  logic [15:0] operation_event_mask;
  logic [15:0] operation_latched_events;

  // questionable group registers
  logic [15:0] ques_condition;
  logic [15:0] ques_mask;
  logic [15:0] ques_events;

  // live images and their rising edges
  logic [15:0] next_oper_cond;
  logic [15:0] next_ques_cond;
  logic [15:0] oper_rise;
  logic [15:0] ques_rise;

  // command decode
  logic        is_cmd;
  opstat_cmd_t cmd;
  logic        is_preset;
  logic        is_oper_event_rd;
  logic        is_ques_event_rd;
  logic        is_oper_mask_wr;
  logic        is_ques_mask_wr;

  // pins come from the analog side, two stages before any use
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= {current_regulation_flag, voltage_regulation_flag, current_fault_flag,
                 voltage_fault_flag, current_mode_live_flag, voltage_mode_live_flag};
      sync_b <= sync_a;
    end
  end

  // the code only means something while the strobe is high
  assign cmd    = opstat_cmd_t'(cmd_code);
  assign is_cmd = cmd_valid;

  // one strobe per state-changing command; each register block tests one name, the mask block two
  assign is_preset        = is_cmd && (cmd == OPSTAT_CMD_PRESET);
  assign is_oper_event_rd = is_cmd && (cmd == OPSTAT_CMD_OPER_EVEN_Q);
  assign is_ques_event_rd = is_cmd && (cmd == OPSTAT_CMD_QUES_EVEN_Q);
  assign is_oper_mask_wr  = is_cmd && (cmd == OPSTAT_CMD_OPER_ENAB_W);
  assign is_ques_mask_wr  = is_cmd && (cmd == OPSTAT_CMD_QUES_ENAB_W);

  // live condition images built from synchronised flags
  always_comb begin
    next_oper_cond = OPSTAT_ZERO;
    next_ques_cond = OPSTAT_ZERO;
    next_oper_cond[OPSTAT_CUR_BIT]  = sync_b[5];
    next_oper_cond[OPSTAT_VOLT_BIT] = sync_b[4];
    next_ques_cond[OPSTAT_QCE_BIT]  = sync_b[3];
    next_ques_cond[OPSTAT_QVE_BIT]  = sync_b[2];
    next_ques_cond[OPSTAT_QCM_BIT]  = sync_b[1];
    next_ques_cond[OPSTAT_QVM_BIT]  = sync_b[0];
  end

  // condition registers; preset forces zero so still-active flags rise again
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      operation_live_condition <= OPSTAT_ZERO;
      ques_condition           <= OPSTAT_ZERO;
    end else if (is_preset) begin
      operation_live_condition <= OPSTAT_ZERO;
      ques_condition           <= OPSTAT_ZERO;
    end else begin
      operation_live_condition <= next_oper_cond;
      ques_condition           <= next_ques_cond;
    end
  end

  // positive transitions are the events
  assign oper_rise = next_oper_cond & ~operation_live_condition;
  assign ques_rise = next_ques_cond & ~ques_condition & OPSTAT_QUES_LATCH;

  // operation event latch; a new event beats the clear of a read
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      operation_latched_events <= OPSTAT_ZERO;
    end else if (is_oper_event_rd) begin
      operation_latched_events <= oper_rise;
    end else begin
      operation_latched_events <= operation_latched_events | oper_rise;
    end
  end

  // questionable event latch, only fault bits latch
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ques_events <= OPSTAT_ZERO;
    end else if (is_ques_event_rd) begin
      ques_events <= ques_rise;
    end else begin
      ques_events <= ques_events | ques_rise;
    end
  end

  // enable masks; undefined bits are dropped so reads stay in range
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      operation_event_mask <= OPSTAT_ZERO;
      ques_mask            <= OPSTAT_ZERO;
    end else if (is_oper_mask_wr) begin
      operation_event_mask <= cmd_data & OPSTAT_OPER_DEF;
    end else if (is_ques_mask_wr) begin
      ques_mask <= cmd_data & OPSTAT_QUES_DEF;
    end
  end

  // query answers, one cycle after the command
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
      rsp_data  <= OPSTAT_ZERO;
    end else begin
      rsp_valid <= 1'b0;
      if (is_cmd) begin
        unique case (cmd)
          OPSTAT_CMD_OPER_COND_Q: begin
            rsp_valid <= 1'b1;
            rsp_data  <= operation_live_condition;
          end
          OPSTAT_CMD_OPER_ENAB_Q: begin
            rsp_valid <= 1'b1;
            rsp_data  <= operation_event_mask;
          end
          OPSTAT_CMD_OPER_EVEN_Q: begin
            rsp_valid <= 1'b1;
            rsp_data  <= operation_latched_events;
          end
          OPSTAT_CMD_QUES_COND_Q: begin
            rsp_valid <= 1'b1;
            rsp_data  <= ques_condition;
          end
          OPSTAT_CMD_QUES_EVEN_Q: begin
            rsp_valid <= 1'b1;
            rsp_data  <= ques_events;
          end
          OPSTAT_CMD_QUES_ENAB_Q: begin
            rsp_valid <= 1'b1;
            rsp_data  <= ques_mask;
          end
          OPSTAT_CMD_OPER_ENAB_W,
          OPSTAT_CMD_QUES_ENAB_W,
          OPSTAT_CMD_PRESET: begin
            rsp_valid <= 1'b0;
          end
          default: begin
            // unknown codes are ignored, no answer
            rsp_valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // summary bits, registered so the output is a clean flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status_byte <= 8'h00;
    end else begin
      status_byte <= 8'h00;
      status_byte[OPSTAT_OPER_SUM] <= |(operation_latched_events & operation_event_mask);
      status_byte[OPSTAT_QUES_SUM] <= |(ques_events & ques_mask);
    end
  end

endmodule // opstat_top
`default_nettype wire

// File: testbench.sv
// self-checking bench for the operation status group
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import opstat_pkg::*;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic [5:0]  flg      = 6'h00; // creg vreg cfault vfault cmode vmode
  logic        cmd_valid, rsp_valid;
  logic [3:0]  cmd_code;
  logic [15:0] cmd_data, rsp_data, q;
  logic [7:0]  status_byte;
  int          mismatches = 0;
  int          n_checks   = 0;
  always #2.5 core_clk = ~core_clk;
  opstat_top dut (.core_clk, .resetn, .current_regulation_flag(flg[5]),
    .voltage_regulation_flag(flg[4]), .current_fault_flag(flg[3]), .voltage_fault_flag(flg[2]),
    .current_mode_live_flag(flg[1]), .voltage_mode_live_flag(flg[0]), .cmd_valid, .cmd_code,
    .cmd_data, .rsp_valid, .rsp_data, .status_byte);
  opstat_host host (.core_clk, .rsp_valid, .rsp_data, .cmd_valid, .cmd_code, .cmd_data);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test(input bit hung);
    if (hung) mismatches++;
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic ask(input logic [3:0] c, output logic [15:0] r);
    host.query(c, r);
  endtask
  // pins settle into the registers 3 edges on, summary one more
  task automatic fl(input logic [5:0] v);
    @(posedge core_clk) flg <= v;
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  task automatic t_reset_mask;
    ask(4'h2, q); chk(q, 16'h0000);
    ask(4'h3, q); chk(q, 16'h0000);
    host.send(4'h1, 16'hffff);
    ask(4'h2, q); chk(q, OPSTAT_OPER_DEF);
    host.send(4'h1, 16'h0500);
    ask(4'h2, q); chk(q, 16'h0500);
  endtask
  task automatic t_oper;
    fl(6'h10);
    ask(4'h0, q); chk(q, 16'h0100);
    chk({8'h00, status_byte}, 16'h0080);
    ask(4'h3, q); chk(q, 16'h0100);
    ask(4'h3, q); chk(q, 16'h0000);
    chk({8'h00, status_byte}, 16'h0000);
    fl(6'h30);
    fl(6'h10);
    ask(4'h0, q); chk(q, 16'h0100);
    ask(4'h3, q); chk(q, 16'h0400);
  endtask
  task automatic t_ques_preset;
    host.send(4'h7, 16'hffff);
    ask(4'h8, q); chk(q, OPSTAT_QUES_DEF);
    fl(6'h1f);
    chk({8'h00, status_byte}, 16'h0008);
    ask(4'h5, q); chk(q, 16'h3003);
    ask(4'h6, q); chk(q, 16'h3000);
    host.send(4'h4, 16'h0000);
    repeat (4) @(posedge core_clk);
    ask(4'h3, q); chk(q, 16'h0100);
    ask(4'h6, q); chk(q, 16'h3000);
    host.send(4'h1, 16'h0000);
  endtask
  // unknown code must neither answer nor touch the mask
  task automatic t_unknown;
    host.send(4'h9, 16'hffff);
    #1;
    chk({15'h0000, rsp_valid}, 16'h0000);
    ask(4'h2, q); chk(q, 16'h0000);
  endtask
  // reset in mid-run drops the mask, condition retracks the live flags
  task automatic t_mid_reset;
    host.send(4'h1, 16'h0500);
    @(posedge core_clk) resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    ask(4'h2, q); chk(q, 16'h0000);
    ask(4'h0, q); chk(q, 16'h0100);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset_mask();
    t_oper();
    t_ques_preset();
    t_unknown();
    t_mid_reset();
    stop_test(1'b0);
  end
endmodule // testbench
`default_nettype wire
